// ===== include/sgf_pkg.sv
// Constants, register map and types of the spindle gear and status flag block
package sgf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_SCODE = 8'h04;
  localparam logic [7:0] OFS_SMAX0 = 8'h08;
  localparam logic [7:0] OFS_UGEAR = 8'h18;
  localparam logic [7:0] OFS_ACMD  = 8'h1C;
  localparam logic [7:0] OFS_AMAX  = 8'h20;
  localparam logic [7:0] OFS_AMIN  = 8'h24;
  localparam logic [7:0] OFS_FBMAX = 8'h28;
  localparam logic [7:0] OFS_FBMIN = 8'h2C;
  localparam logic [7:0] OFS_RATED = 8'h30;
  localparam logic [7:0] OFS_VPCT  = 8'h34;
  localparam logic [7:0] OFS_FLAGS = 8'h38;
  localparam logic [7:0] OFS_ISTAT = 8'h3C;
  localparam logic [7:0] OFS_IMASK = 8'h40;
  localparam int         ADDR_LSB  = 2;
  localparam int         NSTAGE    = 4;
  // Widths
  localparam int SW  = 16;
  localparam int PW  = 7;
  localparam int CW  = 8;
  localparam int NFL = 8;
  localparam int PRW = 24;
  // Control bits
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_LINK = 1;
  // Flag and status bit positions
  localparam int FL_STB = 0;
  localparam int FL_NOG = 1;
  localparam int FL_ILL = 2;
  localparam int FL_CLP = 3;
  localparam int FL_OVR = 4;
  localparam int FL_UND = 5;
  localparam int FL_CUR = 6;
  localparam int FL_VDT = 7;
  // Limits and reset values
  localparam logic [2:0]    GEAR_NUM_MAX = 3'h4;
  localparam logic [PW-1:0] PCT_MIN      = 7'h01;
  localparam logic [PW-1:0] PCT_MAX      = 7'h78;
  localparam logic [PW-1:0] PCT_DEF      = 7'h0A;
  localparam logic [PW-1:0] PCT_SCALE    = 7'h64;
  localparam logic [CW-1:0] CUR_NEAR     = 8'h6E;
  localparam logic [SW-1:0] SPD_RST_MAX  = 16'hFFFF;
  localparam logic [SW-1:0] SPD_RST_MIN  = 16'h0000;
  localparam logic [2:0]    HSIZE_WORD   = 3'h2;
  localparam logic [1:0]    HRESP_OKAY   = 2'h0;
  // Bus phase tracker
  typedef enum logic [1:0] {
    SGF_IDLE = 2'b00,
    SGF_WR   = 2'b01,
    SGF_RDW  = 2'b10,
    SGF_RDD  = 2'b11
  } sgf_bus_t;
endpackage

// ===== design/sgf_spindle_flags.sv
// Spindle gear code and status flag generator with AHB-Lite registers
`timescale 1ns/1ns
`default_nettype none
module sgf_spindle_flags (
  // Clock, reset, scan enable
  input  wire logic                     hclk,
  input  wire logic                     hresetn,
  input  wire logic                     ce,
  // AHB-Lite slave
  input  wire logic                     hsel,
  input  wire logic [31:0]              haddr,
  input  wire logic [1:0]               htrans,
  input  wire logic                     hwrite,
  input  wire logic [2:0]               hsize,
  input  wire logic [31:0]              hwdata,
  input  wire logic                     hready,
  output logic                          hreadyout,
  output logic [1:0]                    hresp,
  output logic [31:0]                   hrdata,
  // Drive feedback pins, asynchronous
  input  wire logic [sgf_pkg::SW-1:0]   speed_fb,
  input  wire logic [sgf_pkg::CW-1:0]   current_pct,
  // Sequence program handshake
  input  wire logic                     code_finish,
  output logic                          spindle_code_strobe,
  output logic                          gear_code_low_bit,
  output logic                          gear_code_high_bit,
  output logic                          no_gear_match_flag,
  // Status flags
  output logic                          gear_number_illegal_flag,
  output logic                          analog_command_clamped_flag,
  output logic                          speed_above_max_flag,
  output logic                          speed_below_min_flag,
  output logic                          current_near_limit_flag,
  output logic                          speed_below_setpoint_flag,
  output logic [sgf_pkg::SW-1:0]        analog_cmd_out,
  output logic                          irq
);

  // Lowest stage whose limit covers the code wins; bit 2 marks a match
  function automatic logic [2:0] gear_sel(input logic [sgf_pkg::SW-1:0] s,
                                          input logic [3:0][sgf_pkg::SW-1:0] lim);
    logic [2:0] r;
    r = 3'h0;
    for (int i = sgf_pkg::NSTAGE - 1; i >= 0; i--)
    begin
      if (s <= lim[i])
      begin
        r = {1'b1, i[1:0]};
      end
    end
    return r;
  endfunction

  // State
  sgf_pkg::sgf_bus_t               st_q;
  logic [7:0]                      addr_q;
  logic [1:0]                      ctrl_q;
  logic [sgf_pkg::SW-1:0]          scode_q;
  logic [3:0][sgf_pkg::SW-1:0]     smax_q;
  logic [2:0]                      ugear_q;
  logic [sgf_pkg::SW-1:0]          acmd_q;
  logic [sgf_pkg::SW-1:0]          amax_q;
  logic [sgf_pkg::SW-1:0]          amin_q;
  logic [sgf_pkg::SW-1:0]          fbmax_q;
  logic [sgf_pkg::SW-1:0]          fbmin_q;
  logic [sgf_pkg::SW-1:0]          rated_q;
  logic [sgf_pkg::PW-1:0]          vpct_q;
  logic [sgf_pkg::NFL-1:0]         flags_q;
  logic [sgf_pkg::NFL-1:0]         istat_q;
  logic [sgf_pkg::NFL-1:0]         imask_q;
  logic [1:0]                      gear_q;
  logic [sgf_pkg::SW-1:0]          fb_m_q;
  logic [sgf_pkg::SW-1:0]          fb_s_q;
  logic [sgf_pkg::CW-1:0]          cur_m_q;
  logic [sgf_pkg::CW-1:0]          cur_s_q;
  logic [31:0]                     hrdata_q;

  // Bus decode
  wire        acc     = ce & hsel & hready & htrans[1] & (hsize == sgf_pkg::HSIZE_WORD);
  wire        wr_en   = ce & (st_q == sgf_pkg::SGF_WR);
  wire        rd_ld   = ce & (st_q == sgf_pkg::SGF_RDW);
  wire        wr_scd  = wr_en & (addr_q == sgf_pkg::OFS_SCODE);
  wire        rd_clr  = rd_ld & (addr_q == sgf_pkg::OFS_ISTAT);
  wire [2:0]  gsel    = gear_sel(hwdata[sgf_pkg::SW-1:0], smax_q);
  wire        auto_is = wr_scd & ctrl_q[sgf_pkg::CTRL_AUTO];
  wire [sgf_pkg::PW-1:0] pct_wr = hwdata[sgf_pkg::PW-1:0];
  wire        pct_ok  = (pct_wr >= sgf_pkg::PCT_MIN) & (pct_wr <= sgf_pkg::PCT_MAX);
  wire        link    = ctrl_q[sgf_pkg::CTRL_LINK];

  // Flag conditions; the feedback ones compare the synchronised fb_s_q and cur_s_q
  wire [sgf_pkg::PRW-1:0] fb_scaled  = sgf_pkg::PRW'(fb_s_q) * sgf_pkg::PRW'(sgf_pkg::PCT_SCALE);
  wire [sgf_pkg::PRW-1:0] thr_scaled = sgf_pkg::PRW'(rated_q) * sgf_pkg::PRW'(vpct_q);
  wire        c_ill = ugear_q > sgf_pkg::GEAR_NUM_MAX;
  wire        c_hi  = acmd_q > amax_q;
  wire        c_lo  = acmd_q < amin_q;
  wire        c_ovr = fb_s_q > fbmax_q;
  wire        c_und = fb_s_q < fbmin_q;
  wire        c_cur = link & (cur_s_q >= sgf_pkg::CUR_NEAR);
  wire        c_vdt = link & (fb_scaled < thr_scaled);
  // Strobe wins over finish when both land in one cycle
  wire        stb_d = wr_scd | (flags_q[sgf_pkg::FL_STB] & ~code_finish);
  wire        nog_d = auto_is ? ~gsel[2] : (flags_q[sgf_pkg::FL_NOG] & stb_d);
  wire [sgf_pkg::NFL-1:0] flags_d = {c_vdt, c_cur, c_und, c_ovr,
                                     c_hi | c_lo, c_ill, nog_d, stb_d};
  // Events are rising edges of each flag
  wire [sgf_pkg::NFL-1:0] ev      = flags_d & ~flags_q;
  wire [sgf_pkg::NFL-1:0] istat_d = (istat_q & ~{sgf_pkg::NFL{rd_clr}}) | ev;

  // Register read selection
  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      sgf_pkg::OFS_CTRL:  r = 32'(ctrl_q);
      sgf_pkg::OFS_SCODE: r = 32'(scode_q);
      sgf_pkg::OFS_UGEAR: r = 32'(ugear_q);
      sgf_pkg::OFS_ACMD:  r = 32'(acmd_q);
      sgf_pkg::OFS_AMAX:  r = 32'(amax_q);
      sgf_pkg::OFS_AMIN:  r = 32'(amin_q);
      sgf_pkg::OFS_FBMAX: r = 32'(fbmax_q);
      sgf_pkg::OFS_FBMIN: r = 32'(fbmin_q);
      sgf_pkg::OFS_RATED: r = 32'(rated_q);
      sgf_pkg::OFS_VPCT:  r = 32'(vpct_q);
      sgf_pkg::OFS_FLAGS: r = 32'({gear_q, flags_q});
      sgf_pkg::OFS_ISTAT: r = 32'(istat_q);
      sgf_pkg::OFS_IMASK: r = 32'(imask_q);
      default:
      begin
        for (int i = 0; i < sgf_pkg::NSTAGE; i++)
        begin
          if (a == sgf_pkg::OFS_SMAX0 + 8'(i << sgf_pkg::ADDR_LSB))
          begin
            r = 32'(smax_q[i]);
          end
        end
      end
    endcase
    return r;
  endfunction

  // Reads take one wait state so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q   <= sgf_pkg::SGF_IDLE;
      addr_q <= 8'h00;
    end
    else if (ce)
    begin
      case (st_q)
        sgf_pkg::SGF_RDW: st_q <= sgf_pkg::SGF_RDD;
        sgf_pkg::SGF_IDLE,
        sgf_pkg::SGF_WR,
        sgf_pkg::SGF_RDD:
        begin
          if (acc)
          begin
            st_q   <= hwrite ? sgf_pkg::SGF_WR : sgf_pkg::SGF_RDW;
            addr_q <= haddr[7:0];
          end
          else
          begin
            st_q <= sgf_pkg::SGF_IDLE;
          end
        end
        default: st_q <= sgf_pkg::SGF_IDLE;
      endcase
    end
  end

  // Read data, loaded in the wait state; interrupt status is read-cleared in the flag block
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_q <= 32'h0000_0000;
    else if (rd_ld)
      hrdata_q <= reg_read(addr_q);
  end

  // Control and parameter registers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_q  <= 2'b00;
      scode_q <= sgf_pkg::SPD_RST_MIN;
      ugear_q <= 3'h0;
      acmd_q  <= sgf_pkg::SPD_RST_MIN;
      amax_q  <= sgf_pkg::SPD_RST_MAX;
      amin_q  <= sgf_pkg::SPD_RST_MIN;
      fbmax_q <= sgf_pkg::SPD_RST_MAX;
      fbmin_q <= sgf_pkg::SPD_RST_MIN;
      rated_q <= sgf_pkg::SPD_RST_MAX;
      vpct_q  <= sgf_pkg::PCT_DEF;
      imask_q <= 8'h00;
    end
    else if (wr_en)
    begin
      case (addr_q)
        sgf_pkg::OFS_CTRL:  ctrl_q  <= hwdata[1:0];
        sgf_pkg::OFS_SCODE: scode_q <= hwdata[sgf_pkg::SW-1:0];
        sgf_pkg::OFS_UGEAR: ugear_q <= hwdata[2:0];
        sgf_pkg::OFS_ACMD:  acmd_q  <= hwdata[sgf_pkg::SW-1:0];
        sgf_pkg::OFS_AMAX:  amax_q  <= hwdata[sgf_pkg::SW-1:0];
        sgf_pkg::OFS_AMIN:  amin_q  <= hwdata[sgf_pkg::SW-1:0];
        sgf_pkg::OFS_FBMAX: fbmax_q <= hwdata[sgf_pkg::SW-1:0];
        sgf_pkg::OFS_FBMIN: fbmin_q <= hwdata[sgf_pkg::SW-1:0];
        sgf_pkg::OFS_RATED: rated_q <= hwdata[sgf_pkg::SW-1:0];
        sgf_pkg::OFS_VPCT:  vpct_q  <= pct_ok ? pct_wr : vpct_q;
        sgf_pkg::OFS_IMASK: imask_q <= hwdata[sgf_pkg::NFL-1:0];
        default: ;
      endcase
    end
  end

  // Four stage limits, one register each
  for (genvar g = 0; g < sgf_pkg::NSTAGE; g++)
  begin : g_smax
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        smax_q[g] <= sgf_pkg::SPD_RST_MAX;
      else if (wr_en && addr_q == sgf_pkg::OFS_SMAX0 + 8'(g << sgf_pkg::ADDR_LSB))
        smax_q[g] <= hwdata[sgf_pkg::SW-1:0];
    end
  end

  // Feedback pins cross in through two flops; words may tear for one scan
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fb_m_q  <= sgf_pkg::SPD_RST_MIN;
      fb_s_q  <= sgf_pkg::SPD_RST_MIN;
      cur_m_q <= 8'h00;
      cur_s_q <= 8'h00;
    end
    else if (ce)
    begin
      fb_m_q  <= speed_fb;
      fb_s_q  <= fb_m_q;
      cur_m_q <= current_pct;
      cur_s_q <= cur_m_q;
    end
  end

  // Flags refreshed every scan; gear code latched only on an auto issue
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      flags_q <= 8'h00;
      gear_q  <= 2'b00;
      istat_q <= 8'h00;
    end
    else if (ce)
    begin
      flags_q <= flags_d;
      istat_q <= istat_d;
      if (auto_is)
        gear_q <= gsel[2] ? gsel[1:0] : gear_q;
    end
  end

  // Outputs
  assign hreadyout                   = st_q != sgf_pkg::SGF_RDW;
  assign hresp                       = sgf_pkg::HRESP_OKAY;
  assign hrdata                      = hrdata_q;
  assign spindle_code_strobe         = flags_q[sgf_pkg::FL_STB];
  assign gear_code_low_bit           = gear_q[0];
  assign gear_code_high_bit          = gear_q[1];
  assign no_gear_match_flag          = flags_q[sgf_pkg::FL_NOG];
  assign gear_number_illegal_flag    = flags_q[sgf_pkg::FL_ILL];
  assign analog_command_clamped_flag = flags_q[sgf_pkg::FL_CLP];
  assign speed_above_max_flag        = flags_q[sgf_pkg::FL_OVR];
  assign speed_below_min_flag        = flags_q[sgf_pkg::FL_UND];
  assign current_near_limit_flag     = flags_q[sgf_pkg::FL_CUR];
  assign speed_below_setpoint_flag   = flags_q[sgf_pkg::FL_VDT];
  assign irq                         = |(istat_q & imask_q);
  // Clamp is pure selection of registers; the registered flag agrees with the value one scan later
  assign analog_cmd_out = c_hi ? amax_q : (c_lo ? amin_q : acmd_q);

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_auto_issue;
    ce && auto_is;
  endsequence
  sequence s_fin_only;
    ce && spindle_code_strobe && code_finish && !wr_scd;
  endsequence

  property p_gear_code;
    s_auto_issue and gsel[2] |=> spindle_code_strobe
      && {gear_code_high_bit, gear_code_low_bit} == $past(gsel[1:0]);
  endproperty
  a_gear_code: assert property (p_gear_code) else $error("gear code wrong");
  property p_nog_with_strobe;
    s_auto_issue |=> spindle_code_strobe && no_gear_match_flag == !$past(gsel[2]);
  endproperty
  a_nog_with_strobe: assert property (p_nog_with_strobe)
    else $error("no-gear flag not with strobe");
  property p_nog_needs_strobe;
    no_gear_match_flag |-> spindle_code_strobe;
  endproperty
  a_nog_needs_strobe: assert property (p_nog_needs_strobe)
    else $error("no-gear flag without strobe");
  property p_fin_drop;
    s_fin_only |=> !spindle_code_strobe && !no_gear_match_flag;
  endproperty
  a_fin_drop: assert property (p_fin_drop) else $error("strobe kept after finish");
  property p_illegal;
    ce |=> gear_number_illegal_flag == ($past(ugear_q) > sgf_pkg::GEAR_NUM_MAX);
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal gear flag wrong");
  property p_clamp;
    analog_command_clamped_flag && $stable(acmd_q) && $stable(amax_q) && $stable(amin_q)
      |-> analog_cmd_out == amax_q || analog_cmd_out == amin_q;
  endproperty
  a_clamp: assert property (p_clamp) else $error("clamp value wrong");
  property p_over;
    ce ##1 ce |-> speed_above_max_flag == ($past(fb_s_q) > $past(fbmax_q));
  endproperty
  a_over: assert property (p_over) else $error("above-max flag wrong");
  property p_under;
    ce |=> speed_below_min_flag == ($past(fb_s_q) < $past(fbmin_q));
  endproperty
  a_under: assert property (p_under) else $error("below-min flag wrong");
  property p_cur;
    ce && link && cur_s_q >= sgf_pkg::CUR_NEAR |=> current_near_limit_flag;
  endproperty
  a_cur: assert property (p_cur) else $error("current flag missing");
  property p_nolink;
    ce && !link |=> !current_near_limit_flag && !speed_below_setpoint_flag;
  endproperty
  a_nolink: assert property (p_nolink) else $error("flag without serial link");
  property p_vdt;
    ce && link && fb_scaled < thr_scaled |=> speed_below_setpoint_flag;
  endproperty
  a_vdt: assert property (p_vdt) else $error("speed-detect flag missing");
  property p_pct;
    vpct_q >= sgf_pkg::PCT_MIN && vpct_q <= sgf_pkg::PCT_MAX;
  endproperty
  a_pct: assert property (p_pct) else $error("threshold percent out of range");

endmodule
`default_nettype wire

// ===== verif/sgf_seq_model.sv
// Sequence program model that answers the spindle code strobe with a finish
`timescale 1ns/1ns
`default_nettype none
module sgf_seq_model (
  // Clock and reset
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Handshake with the block
  input  wire logic       spindle_code_strobe,
  input  wire logic [7:0] fin_delay,
  output logic            code_finish
);
  logic [7:0] wait_q;
  // Polls the strobe once a scan; a slow program answers late, never early
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wait_q      <= 8'h00;
      code_finish <= 1'b0;
    end
    else if (!spindle_code_strobe)
    begin
      wait_q      <= 8'h00;
      code_finish <= 1'b0; // Dropped once the strobe is gone
    end
    else if (wait_q >= fin_delay)
      code_finish <= 1'b1;
    else
      wait_q <= wait_q + 8'h01;
  end
endmodule
`default_nettype wire

// ===== verif/sgf_spindle_flags_test.sv
// Self-checking bench for the spindle gear code and status flag block
`timescale 1ns/1ns
`default_nettype none
module sgf_spindle_flags_test;
  logic        hclk, hresetn, ce, hsel, hwrite, hreadyout, code_finish;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, hresp;
  logic [2:0]  hsize;
  logic [15:0] speed_fb, analog_cmd_out;
  logic [7:0]  current_pct, fin_delay;
  logic        strobe, gl, gh, nog, ill, clp, ovr, und, cur, vdt, irq;
  int          mismatches, checked, i, k;
  // Clamp table: command, expected output, expected flag
  logic [15:0] acm [4] = '{16'h07D0, 16'h0032, 16'h01F4, 16'h03E8};
  logic [15:0] aex [4] = '{16'h03E8, 16'h0064, 16'h01F4, 16'h03E8};
  logic        acl [4] = '{1'b1, 1'b1, 1'b0, 1'b0};

  sgf_spindle_flags uut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .speed_fb(speed_fb), .current_pct(current_pct), .code_finish(code_finish),
    .spindle_code_strobe(strobe), .gear_code_low_bit(gl), .gear_code_high_bit(gh),
    .no_gear_match_flag(nog), .gear_number_illegal_flag(ill),
    .analog_command_clamped_flag(clp), .speed_above_max_flag(ovr),
    .speed_below_min_flag(und), .current_near_limit_flag(cur),
    .speed_below_setpoint_flag(vdt), .analog_cmd_out(analog_cmd_out), .irq(irq)
  );

  sgf_seq_model seq (
    .hclk(hclk), .hresetn(hresetn), .spindle_code_strobe(strobe),
    .fin_delay(fin_delay), .code_finish(code_finish)
  );

  // Scan clock, 50 ns period
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end

  task automatic stop_test();
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic chkb(input logic got, input logic exp);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge hclk);
    #1;
  endtask

  // Address phase held until ready, then data phase held until ready
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= 1'b1;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge hclk);
    haddr  <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= 1'b0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  // Issue a speed code, check the strobe group, wait for the finish to drop it
  task automatic issue(input logic [31:0] code, input logic [1:0] gear, input logic ng);
    bus_wr(sgf_pkg::OFS_SCODE, code);
    settle(1);
    chkb(strobe, 1'b1);
    chk({30'h0000_0000, gh, gl}, {30'h0000_0000, gear});
    chkb(nog, ng);
    for (k = 0; k < 40 && strobe !== 1'b0; k++) @(posedge hclk);
    settle(1);
    chkb(strobe | nog, 1'b0);
  endtask

  // Bounded run; a hang ends in the same verdict
  initial
  begin
    #(50 * 20000);
    mismatches++;
    stop_test();
  end

  initial
  begin
    hresetn     = 1'b0;
    ce          = 1'b1;
    hsel        = 1'b1;
    haddr       = 32'h0000_0000;
    htrans      = 2'b00;
    hwrite      = 1'b0;
    hsize       = sgf_pkg::HSIZE_WORD;
    hwdata      = 32'h0000_0000;
    speed_fb    = 16'h1000;
    current_pct = 8'h00;
    fin_delay   = 8'h03;
    mismatches  = 0;
    checked     = 0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    // Reset values and an unmapped place
    bus_rd(sgf_pkg::OFS_VPCT, rd);
    chk(rd, 32'h0000_000A);
    bus_rd(sgf_pkg::OFS_FLAGS, rd);
    chk(rd, 32'h0000_0000);
    bus_rd(8'h50, rd);
    chk(rd, 32'h0000_0000);
    // Gear stages at their exact upper limits, then a code fitting none
    bus_wr(sgf_pkg::OFS_CTRL, 32'h0000_0001);
    for (i = 0; i < 4; i++)
      bus_wr(sgf_pkg::OFS_SMAX0 + 8'(4 * i), 32'(100 * (i + 1)));
    for (i = 0; i < 4; i++)
      issue(32'(100 * (i + 1)), 2'(i), 1'b0);
    fin_delay <= 8'h0C;
    issue(32'h0000_0191, 2'h3, 1'b1);
    bus_wr(sgf_pkg::OFS_CTRL, 32'h0000_0000);
    issue(32'h0000_0191, 2'h3, 1'b0);
    chkb(irq, 1'b0); // Events pending but all masked
    // Gear number boundary
    bus_wr(sgf_pkg::OFS_UGEAR, 32'h0000_0004);
    settle(2);
    chkb(ill, 1'b0);
    bus_wr(sgf_pkg::OFS_UGEAR, 32'h0000_0005);
    settle(2);
    chkb(ill, 1'b1);
    // Analog command clamping
    bus_wr(sgf_pkg::OFS_AMAX, 32'h0000_03E8);
    bus_wr(sgf_pkg::OFS_AMIN, 32'h0000_0064);
    for (i = 0; i < 4; i++)
    begin
      bus_wr(sgf_pkg::OFS_ACMD, {16'h0000, acm[i]});
      settle(2);
      chk({16'h0000, analog_cmd_out}, {16'h0000, aex[i]});
      chkb(clp, acl[i]);
    end
    // Speed limits with the interrupt raised, read-cleared
    bus_wr(sgf_pkg::OFS_FBMAX, 32'h0000_8000);
    bus_wr(sgf_pkg::OFS_FBMIN, 32'h0000_0100);
    bus_wr(sgf_pkg::OFS_IMASK, 32'h0000_0001 << sgf_pkg::FL_OVR);
    bus_rd(sgf_pkg::OFS_ISTAT, rd);
    speed_fb <= 16'h9000;
    settle(5);
    chkb(ovr, 1'b1);
    chkb(und, 1'b0);
    chkb(irq, 1'b1);
    bus_rd(sgf_pkg::OFS_ISTAT, rd);
    chk(rd & 32'h0000_0010, 32'h0000_0010);
    settle(1);
    chkb(irq, 1'b0);
    speed_fb <= 16'h0080;
    settle(5);
    chkb(ovr, 1'b0);
    chkb(und, 1'b1);
    // Current flag needs the serial link
    current_pct <= 8'h78;
    settle(5);
    chkb(cur, 1'b0);
    bus_wr(sgf_pkg::OFS_CTRL, 32'h0000_0003);
    current_pct <= 8'h6D;
    settle(5);
    chkb(cur, 1'b0);
    current_pct <= 8'h6E;
    settle(5);
    chkb(cur, 1'b1);
    // Speed detect at the default and the top threshold
    bus_wr(sgf_pkg::OFS_RATED, 32'h0000_03E8);
    speed_fb <= 16'h0063;
    settle(5);
    chkb(vdt, 1'b1);
    speed_fb <= 16'h0064;
    settle(5);
    chkb(vdt, 1'b0);
    bus_wr(sgf_pkg::OFS_VPCT, 32'h0000_0079);
    bus_wr(sgf_pkg::OFS_VPCT, 32'h0000_0000);
    bus_rd(sgf_pkg::OFS_VPCT, rd);
    chk(rd, 32'h0000_000A);
    bus_wr(sgf_pkg::OFS_VPCT, 32'h0000_0078);
    speed_fb <= 16'h04AF;
    settle(5);
    chkb(vdt, 1'b1);
    speed_fb <= 16'h04B0;
    settle(5);
    chkb(vdt, 1'b0);
    // Scan enable low freezes every flag; they catch up once it returns
    @(posedge hclk);
    ce       <= 1'b0;
    speed_fb <= 16'h0000;
    settle(5);
    chkb(vdt, 1'b0);
    @(posedge hclk);
    ce <= 1'b1;
    settle(5);
    chkb(vdt, 1'b1);
    // A byte-sized write is ignored, so the illegal gear number stays
    hsize <= 3'h0;
    bus_wr(sgf_pkg::OFS_UGEAR, 32'h0000_0000);
    hsize <= sgf_pkg::HSIZE_WORD;
    settle(2);
    chkb(ill, 1'b1);
    // Reset in mid-run drops every flag and the gear code, defaults return
    @(posedge hclk);
    hresetn <= 1'b0;
    settle(2);
    chk({22'h00_0000, gh, gl, vdt, cur, und, ovr, clp, ill, nog, strobe}, 32'h0);
    chk({29'h0000_0000, hresp, hreadyout}, {29'h0000_0000, sgf_pkg::HRESP_OKAY, 1'b1});
    @(posedge hclk);
    hresetn <= 1'b1;
    bus_rd(sgf_pkg::OFS_VPCT, rd);
    chk(rd, 32'h0000_000A);
    stop_test();
  end
endmodule
`default_nettype wire
